//--- line_period_sag_peak_monitor.sv
// Purpose: Line period, sag, peak, temperature, delay trim and rms.
// Assumes: Register port and samples come from logic on core_clk.
// Notes: irq_n is made open-drain at the pad.
//
// Contract
// RULE_01: Period measured on the selected phase.
// RULE_02: Period is 15-bit unsigned, refreshed each period.
// RULE_03: Host matches zero-cross enables with period select.
// RULE_04: Period counter ticks every 2.4 microseconds.
// RULE_05: Sag runs on all phases, shared settings.
// RULE_06: Sag flag set after last low half cycle.
// RULE_07: Enabled sag flag pulls interrupt low.
// RULE_08: Sag level compared with magnitude of byte.
// RULE_09: Below only when level exceeds magnitude.
// RULE_10: Peak phase selected, voltage and current both.
// RULE_11: Peak when threshold below sample magnitude.
// RULE_12: Voltage peak sets flag, enabled drives interrupt.
// RULE_13: Temperature sampled every four master clocks.
// RULE_14: Temperature readable at 08h, twos complement.
// RULE_15: Temperature code is degrees minus 129, over 4.
// RULE_16: Five-bit signed trim steps voltage delay 1.2us.
// RULE_17: Negative trim shortens voltage path delay.
// RULE_18: Host trims only small phase errors.
// RULE_19: Rms is root of low-passed square.
// RULE_20: Six rms channels run together, own registers.
// RULE_21: Reading the clear-on-read status zeroes flags.
// RULE_22: Measurement mode register sits at 0Bh.
// RULE_23: Sag count restarts on any high sample.
`timescale 1ns/10ps
`default_nettype none
`include "line_mon_defines.svh"

module line_period_sag_peak_monitor #(
  parameter int unsigned DELAY_AW = 6,
  parameter int unsigned RMS_SHIFT = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [23:0] reg_rdata,
  input wire logic sample_valid,
  input wire line_mon_pkg::volt_trio_t volt_sample,
  input wire line_mon_pkg::curr_trio_t curr_sample,
  input wire line_mon_pkg::temp_deg_t temp_sense_deg,
  output logic irq_n
);
  import line_mon_pkg::*;

  // The pointer must span the widest delay of 32 steps plus one.
  if (DELAY_AW < 6 || DELAY_AW > 10) $error("DELAY_AW out of range");
  if (`PERIOD_TICK_CYC < 1 || `PERIOD_TICK_CYC > 127) $error("tick count too wide");
  if (`TRIM_STEP_CYC < 1 || `TRIM_STEP_CYC > 63) $error("step count too wide");

  // All block state in one word.
  typedef struct packed {
    logic [7:0] mode;          // Measurement mode register.
    logic [15:0] irq_en;       // Interrupt enables.
    logic [15:0] status;       // Sticky event flags.
    logic [7:0] sag_lvl;       // Sag threshold level.
    logic [7:0] sag_cyc;       // Sag half-cycle count.
    logic [7:0] voltage_peak_threshold;         // Voltage peak threshold.
    logic [7:0] current_peak_threshold;         // Current peak threshold.
    logic [2:0][4:0] trim;     // Per-phase delay trims.
    logic [14:0] period;       // Last line period.
    logic [14:0] period_cnt;   // Running period count.
    logic [6:0] tick_cnt;      // Divider for period ticks.
    logic [5:0] step_cnt;      // Divider for delay steps.
    logic [DELAY_AW-1:0] wr_ptr; // Delay ring write pointer.
    logic vstep_d;             // Delayed samples are valid.
    logic [7:0] temp;          // Temperature code.
    logic [1:0] temp_cnt;      // Temperature sample divider.
    logic [2:0] prev_neg;      // Sign of last sample.
    logic [2:0] half_low;      // Half cycle low so far.
    logic [2:0][7:0] sag_cnt;  // Low half cycles counted.
    logic [23:0] rdata;        // Read data register.
    logic irq_n;               // Interrupt line, low active.
  } mon_state_t;

  mon_state_t st;
  mon_state_t next_st;

  // Magnitude of a signed byte; -128 comes out as 80h unsigned.
  function automatic logic [7:0] mag_byte(input logic [7:0] b);
    mag_byte = b[7] ? (~b + 8'h01) : b;
  endfunction : mag_byte

  // Degrees to code; values below the 8-bit range clamp to 80h.
  function automatic logic [7:0] temp_code(input temp_deg_t deg);
    logic signed [10:0] off;
    logic signed [8:0] q;
    off = 11'(deg) - `TEMP_OFFSET_DEG;
    q = 9'(off >>> 2);
    temp_code = (q[8:7] == 2'b10) ? 8'h80 : q[7:0];
  endfunction : temp_code

  // Read address behind the writer by center plus trim plus one.
  function automatic logic [DELAY_AW-1:0] delay_raddr(
    input logic [DELAY_AW-1:0] ptr,
    input logic [4:0] trim
  );
    delay_raddr = ptr - DELAY_AW'(`DELAY_CENTER + 1)
      - {{(DELAY_AW-5){trim[4]}}, trim};
  endfunction : delay_raddr

  // Event wires seen by the state update and the checks.
  logic [2:0] zx_rise;
  logic [2:0] half_end;
  logic [2:0] below_lvl;
  logic [2:0] sag_fire;
  logic [1:0] perd_sel;
  logic [1:0] peak_sel;
  logic period_hit;
  logic peak_v_hit;
  logic peak_i_hit;
  logic step_tick;
  logic status_clr;
  logic [15:0] status_set;
  logic [15:0] dly_rdata [3];
  logic [23:0] rms_val [6];

  assign perd_sel = st.mode[`MODE_PERD_LSB +: 2];
  assign peak_sel = st.mode[`MODE_PEAK_LSB +: 2];
  assign step_tick = (st.step_cnt == 6'(`TRIM_STEP_CYC - 1));
  assign status_clr = reg_rd && (reg_addr == `ADDR_STATUS_READ_CLEAR);

  // Per-phase detectors share one level and one count setting.
  for (genvar p = 0; p < 3; p++) begin : g_phase
    // Rising crossing: last sample negative, this one not.
    assign zx_rise[p] = sample_valid && st.prev_neg[p] && !volt_sample[p][15];
    // Any sign change closes a half cycle.
    assign half_end[p] = sample_valid && (st.prev_neg[p] != volt_sample[p][15]);
    // Strictly greater level means the sample is low.
    assign below_lvl[p] = st.sag_lvl > mag_byte(volt_sample[p][15:8]); // RULE_08 RULE_09
    // Fires once when the closing half brings the count to target.
    assign sag_fire[p] = half_end[p] && st.half_low[p]
      && (st.sag_cyc != 8'h00)
      && (8'(st.sag_cnt[p] + 8'h01) == st.sag_cyc); // RULE_05 RULE_06
  end

  // Only an enabled, selected phase closes a period.
  assign period_hit = sample_valid && (perd_sel != 2'h3)
    && zx_rise[perd_sel] && st.mode[`MODE_ZX_LSB + perd_sel]; // RULE_01 RULE_03

  // Voltage and current of one phase are watched together.
  assign peak_v_hit = sample_valid && (peak_sel != 2'h3)
    && (st.voltage_peak_threshold < mag_byte(volt_sample[peak_sel][15:8])); // RULE_10 RULE_11
  assign peak_i_hit = sample_valid && (peak_sel != 2'h3)
    && (st.current_peak_threshold < mag_byte(curr_sample[peak_sel][23:16])); // RULE_10 RULE_11

  // Flags raised this cycle.
  always_comb begin
    status_set = 16'h0000;
    status_set[`ST_SAG_LSB +: 3] = sag_fire; // RULE_06
    status_set[`ST_ZX_LSB +: 3] = zx_rise & st.mode[`MODE_ZX_LSB +: 3];
    status_set[`ST_PKI] = peak_i_hit;
    status_set[`ST_PKV] = peak_v_hit; // RULE_12
  end

  // Voltage delay lines, stepped at the trim rate.
  for (genvar p = 0; p < 3; p++) begin : g_delay
    delay_if #(.W(16), .AW(DELAY_AW)) dport ();
    sample_delay_mem #(.W(16), .AW(DELAY_AW)) u_mem (
      .clk(core_clk),
      .reset_n(reset_n),
      .port(dport.mem)
    );
    assign dport.wr = step_tick; // RULE_16
    assign dport.waddr = st.wr_ptr;
    assign dport.wdata = volt_sample[p];
    // Smaller trim reads newer words, so the voltage leads.
    assign dport.raddr = delay_raddr(st.wr_ptr, st.trim[p]); // RULE_16 RULE_17
    assign dly_rdata[p] = dport.rdata;
  end

  // Six rms units run side by side, each with its own result.
  for (genvar c = 0; c < 3; c++) begin : g_rms
    rms_if #(.W(16)) vlink ();
    rms_if #(.W(24)) ilink ();
    assign vlink.sample = dly_rdata[c];
    assign vlink.valid = st.vstep_d;
    assign ilink.sample = curr_sample[c];
    assign ilink.valid = sample_valid;
    rms_channel #(.W(16), .SHIFT(RMS_SHIFT)) u_vrms (
      .clk(core_clk),
      .reset_n(reset_n),
      .link(vlink.unit)
    );
    rms_channel #(.W(24), .SHIFT(RMS_SHIFT)) u_irms (
      .clk(core_clk),
      .reset_n(reset_n),
      .link(ilink.unit)
    );
    assign rms_val[c] = {8'h00, vlink.result}; // RULE_20
    assign rms_val[c+3] = ilink.result; // RULE_20
  end

  // Next state of the whole block.
  always_comb begin
    next_st = st;

    // Period divider and counter; the count saturates.
    if (st.tick_cnt == 7'(`PERIOD_TICK_CYC - 1)) begin
      next_st.tick_cnt = 7'h00;
      if (st.period_cnt != 15'h7fff) begin
        next_st.period_cnt = st.period_cnt + 15'h0001; // RULE_04
      end
    end else begin
      next_st.tick_cnt = st.tick_cnt + 7'h01;
    end
    if (period_hit) begin
      next_st.period = st.period_cnt; // RULE_02
      next_st.period_cnt = 15'h0000;
    end

    // Delay ring advances one word per step.
    if (step_tick) begin
      next_st.step_cnt = 6'h00;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end else begin
      next_st.step_cnt = st.step_cnt + 6'h01;
    end
    next_st.vstep_d = step_tick;

    // Half-cycle sag counting for each phase.
    for (int p = 0; p < 3; p++) begin
      if (sample_valid) begin
        next_st.prev_neg[p] = volt_sample[p][15];
      end
      if (half_end[p]) begin
        if (st.half_low[p] && st.sag_cnt[p] != 8'hff) begin
          next_st.sag_cnt[p] = st.sag_cnt[p] + 8'h01; // RULE_06
        end
        next_st.half_low[p] = 1'b1;
      end
      // A sample at or above the level restarts the run.
      if (sample_valid && !below_lvl[p]) begin
        next_st.half_low[p] = 1'b0;
        next_st.sag_cnt[p] = 8'h00; // RULE_23
      end
    end

    // Temperature is taken once per four clocks.
    next_st.temp_cnt = st.temp_cnt + 2'h1;
    if (st.temp_cnt == 2'(`TEMP_CYC - 1)) begin
      next_st.temp = temp_code(temp_sense_deg); // RULE_13 RULE_15
    end

    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_MODE: next_st.mode = reg_wdata[7:0]; // RULE_22
        `ADDR_IRQ_EN: next_st.irq_en = reg_wdata;
        `ADDR_SAG_CYC: next_st.sag_cyc = reg_wdata[7:0];
        `ADDR_SAG_LVL: next_st.sag_lvl = reg_wdata[7:0];
        `ADDR_CURRENT_PEAK_THRESHOLD: next_st.current_peak_threshold = reg_wdata[7:0];
        `ADDR_VOLTAGE_PEAK_THRESHOLD: next_st.voltage_peak_threshold = reg_wdata[7:0];
        `ADDR_TRIM_A: next_st.trim[0] = reg_wdata[4:0];
        6'(`ADDR_TRIM_A + 1): next_st.trim[1] = reg_wdata[4:0];
        6'(`ADDR_TRIM_A + 2): next_st.trim[2] = reg_wdata[4:0];
        // Read-only and unmapped addresses ignore writes.
        default: begin
        end
      endcase
    end

    // Reads answer one clock later; unmapped reads give zero.
    if (reg_rd) begin
      next_st.rdata = 24'h000000;
      for (int c = 0; c < 6; c++) begin
        if (reg_addr == 6'(`ADDR_RMS_BASE + c)) begin
          next_st.rdata = rms_val[c]; // RULE_20
        end
      end
      case (reg_addr)
        `ADDR_PERIOD: next_st.rdata = {9'h000, st.period};
        `ADDR_TEMP: next_st.rdata = {16'h0000, st.temp}; // RULE_14
        `ADDR_MODE: next_st.rdata = {16'h0000, st.mode};
        `ADDR_IRQ_EN: next_st.rdata = {8'h00, st.irq_en};
        `ADDR_STATUS: next_st.rdata = {8'h00, st.status};
        `ADDR_STATUS_READ_CLEAR: next_st.rdata = {8'h00, st.status};
        `ADDR_SAG_CYC: next_st.rdata = {16'h0000, st.sag_cyc};
        `ADDR_SAG_LVL: next_st.rdata = {16'h0000, st.sag_lvl};
        `ADDR_CURRENT_PEAK_THRESHOLD: next_st.rdata = {16'h0000, st.current_peak_threshold};
        `ADDR_VOLTAGE_PEAK_THRESHOLD: next_st.rdata = {16'h0000, st.voltage_peak_threshold};
        `ADDR_TRIM_A: next_st.rdata = {19'h00000, st.trim[0]};
        6'(`ADDR_TRIM_A + 1): next_st.rdata = {19'h00000, st.trim[1]};
        6'(`ADDR_TRIM_A + 2): next_st.rdata = {19'h00000, st.trim[2]};
        default: begin
        end
      endcase
    end

    // A flag raised in the clearing cycle survives the clear.
    next_st.status = (st.status & ~{16{status_clr}}) | status_set; // RULE_21

    // The line is low while any enabled flag stands.
    next_st.irq_n = ~|(next_st.status & next_st.irq_en); // RULE_07 RULE_12
  end

  // Single state register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.mode <= `MODE_RESET;
      st.irq_en <= `IRQ_EN_RESET;
      st.sag_lvl <= `THRESH_RESET;
      st.voltage_peak_threshold <= `THRESH_RESET;
      st.current_peak_threshold <= `THRESH_RESET;
      st.irq_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq_n = st.irq_n;

  // Checks on the behaviour above.
  a_period_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    period_hit |=> st.period == $past(st.period_cnt)) // RULE_02
    else $error("period not loaded on crossing");

  a_tick_spacing: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!period_hit && st.period_cnt != 15'h7fff && st.tick_cnt == 7'h00)
    ##1 (st.tick_cnt != 7'h00 && !period_hit) [*3] |-> $stable(st.period_cnt)) // RULE_04
    else $error("period count moved between ticks");

  a_sag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    sag_fire[0] |=> st.status[`ST_SAG_LSB]) // RULE_06
    else $error("sag flag not set");

  a_sag_below: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sample_valid && half_end[1] && st.half_low[1] && below_lvl[1]
     && st.sag_cnt[1] < 8'hfe)
    |=> st.sag_cnt[1] == $past(st.sag_cnt[1]) + 8'h01) // RULE_05 RULE_09
    else $error("sag count did not advance");

  a_sag_restart: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sample_valid && !below_lvl[2]) |=> (st.sag_cnt[2] == 8'h00 && !st.half_low[2])) // RULE_23
    else $error("sag count not restarted");

  a_peak_volt: assert property (@(posedge core_clk) disable iff (!reset_n)
    peak_v_hit |=> st.status[`ST_PKV]) // RULE_11
    else $error("voltage peak flag missing");

  a_irq_pkv: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st.status[`ST_PKV] && st.irq_en[`ST_PKV] && !status_clr && !reg_wr)
    |=> !irq_n [*1]) // RULE_12
    else $error("interrupt not low on voltage peak");

  a_irq_sag: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sag_fire[0] && st.irq_en[`ST_SAG_LSB] && !reg_wr) |=> !irq_n) // RULE_07
    else $error("interrupt not low on sag");

  a_temp_rate: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st.temp != $past(st.temp)) |-> $past(st.temp_cnt) == 2'h3) // RULE_13
    else $error("temperature updated off schedule");

  a_status_read_clear_clr: assert property (@(posedge core_clk) disable iff (!reset_n)
    (status_clr && status_set == 16'h0000) |=> st.status == 16'h0000) // RULE_21
    else $error("status not cleared by read");

  a_mode_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == 6'h0b) |=> st.mode == $past(reg_wdata[7:0])) // RULE_22
    else $error("mode register write lost");
endmodule : line_period_sag_peak_monitor
`default_nettype wire

//--- line_mon_defines.svh
// Purpose: Offsets, field positions, resets and timing counts.
// Assumes: Included by bare name, definitions only.
// Notes: Register addresses on the serial register port.
`ifndef LINE_MON_DEFINES_SVH
`define LINE_MON_DEFINES_SVH
`define ADDR_PERIOD 6'h07
`define ADDR_TEMP 6'h08
`define ADDR_MODE 6'h0b
`define ADDR_IRQ_EN 6'h0f
`define ADDR_STATUS 6'h10
`define ADDR_STATUS_READ_CLEAR 6'h11
`define ADDR_SAG_CYC 6'h13
`define ADDR_SAG_LVL 6'h14
`define ADDR_CURRENT_PEAK_THRESHOLD 6'h15
`define ADDR_VOLTAGE_PEAK_THRESHOLD 6'h16
`define ADDR_TRIM_A 6'h17
`define ADDR_RMS_BASE 6'h1a
`define MODE_PERD_LSB 0
`define MODE_PEAK_LSB 2
`define MODE_ZX_LSB 4
`define ST_SAG_LSB 1
`define ST_ZX_LSB 7
`define ST_PKI 10
`define ST_PKV 11
`define MODE_RESET 8'h70
`define IRQ_EN_RESET 16'h0000
`define THRESH_RESET 8'h00
`define CLK_FREQ_MHZ 50
`define PERIOD_TICK_NS 2400
`define PERIOD_TICK_CYC ((`PERIOD_TICK_NS * `CLK_FREQ_MHZ) / 1000)
`define TRIM_STEP_NS 1200
`define TRIM_STEP_CYC ((`TRIM_STEP_NS * `CLK_FREQ_MHZ) / 1000)
`define TEMP_CYC 4
`define DELAY_CENTER 16
`define TEMP_OFFSET_DEG 11'sh081
`endif

//--- line_mon_pkg.sv
// Purpose: Types shared by the monitor modules.
// Assumes: Nothing.
// Notes: Constants live in the defines header.
package line_mon_pkg;
  typedef logic [15:0] volt_word_t;
  typedef logic [23:0] curr_word_t;
  typedef volt_word_t [2:0] volt_trio_t;
  typedef curr_word_t [2:0] curr_trio_t;
  typedef logic signed [9:0] temp_deg_t;
  typedef enum logic {RMS_IDLE = 1'b0, RMS_ROOT = 1'b1} rms_phase_t;
endpackage : line_mon_pkg

//--- line_mon_links.sv
// Purpose: Links between the monitor and its delay memories and rms units.
// Assumes: One clock.
// Notes: No logic here.
`timescale 1ns/10ps
`default_nettype none
interface delay_if #(parameter int unsigned W = 16, parameter int unsigned AW = 6);
  logic wr;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport mem (input wr, waddr, wdata, raddr, output rdata);
  modport user (output wr, waddr, wdata, raddr, input rdata);
endinterface : delay_if

interface rms_if #(parameter int unsigned W = 24);
  logic [W-1:0] sample;
  logic valid;
  logic [W-1:0] result;
  modport unit (input sample, valid, output result);
  modport feed (output sample, valid, input result);
endinterface : rms_if
`default_nettype wire

//--- sample_delay_mem.sv
// Purpose: Ring memory holding voltage samples for the delay trim.
// Assumes: One write and one read per clock.
// Notes: Read data comes out of a register.
`timescale 1ns/10ps
`default_nettype none
module sample_delay_mem #(
  parameter int unsigned W = 16,
  parameter int unsigned AW = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  delay_if.mem port
);
  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] cells;
    logic [W-1:0] rdata;
  } mem_state_t;
  mem_state_t st;
  mem_state_t next_st;
  if (AW < 6 || W < 8) $error("sample_delay_mem: AW or W too small");
  // Write and registered read; read sees the old word on a collision.
  always_comb begin
    next_st = st;
    if (port.wr) begin
      next_st.cells[port.waddr] = port.wdata;
    end
    next_st.rdata = st.cells[port.raddr];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign port.rdata = st.rdata;
endmodule : sample_delay_mem
`default_nettype wire

//--- rms_channel.sv
// Purpose: Rms of one channel: square, low-pass, square root.
// Assumes: Twos complement samples with a valid strobe.
// Notes: Root takes W cycles; result holds between roots.
`timescale 1ns/10ps
`default_nettype none
module rms_channel
  import line_mon_pkg::*;
#(
  parameter int unsigned W = 24,
  parameter int unsigned SHIFT = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  rms_if.unit link
);
  typedef struct packed {
    rms_phase_t phase;
    logic [2*W-1:0] filt;
    logic [2*W-1:0] target;
    logic [W-1:0] root;
    logic [W-1:0] bitpos;
    logic [W-1:0] result;
  } rms_state_t;
  rms_state_t st;
  rms_state_t next_st;
  logic [W-1:0] mag;
  logic [2*W-1:0] sq;
  logic signed [2*W:0] diff;
  logic [W-1:0] cand;
  logic [2*W-1:0] cand_sq;
  if (W < 8 || W > 24 || SHIFT < 1 || SHIFT >= 2*W) $error("rms_channel: bad W or SHIFT");
  // Square feeds a first-order low-pass; a bitwise root follows. RULE_19
  always_comb begin
    next_st = st;
    mag = link.sample[W-1] ? W'(~link.sample + 1'b1) : link.sample;
    sq = mag * mag;
    diff = $signed({1'b0, sq}) - $signed({1'b0, st.filt});
    cand = st.root | st.bitpos;
    cand_sq = cand * cand;
    if (link.valid) begin
      next_st.filt = st.filt + (2*W)'(diff >>> SHIFT); // RULE_19
    end
    unique case (st.phase)
      RMS_IDLE: begin
        next_st.target = st.filt;
        next_st.root = '0;
        next_st.bitpos = {1'b1, {(W-1){1'b0}}};
        next_st.phase = RMS_ROOT;
      end
      RMS_ROOT: begin
        if (cand_sq <= st.target) begin
          next_st.root = cand;
        end
        next_st.bitpos = st.bitpos >> 1;
        if (st.bitpos[0]) begin
          next_st.result = (cand_sq <= st.target) ? cand : st.root; // RULE_19
          next_st.phase = RMS_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign link.result = st.result;
endmodule : rms_channel
`default_nettype wire

//--- host_model.sv
// Purpose: Host side of the register port, one access at a time.
// Assumes: Strobes change on the falling edge of core_clk.
// Notes: Address and data are inverted after use so stale values cannot pass.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [23:0] reg_rdata
);
  // The port idles with both strobes low.
  initial begin
    reg_addr = 6'h3f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One write pulse, taken at the single rising edge it spans.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // One read pulse; the data is taken a full cycle later, where it is settled.
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the line monitor.
// Assumes: Inputs change on the falling edge of core_clk.
// Notes: Each sample level is held long enough to pass the voltage delay line.
`timescale 1ns/10ps
`default_nettype none
`include "line_mon_defines.svh"
module tb;
  import line_mon_pkg::*;
  logic core_clk;
  logic reset_n;
  logic [5:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [23:0] reg_rdata;
  logic sample_valid;
  volt_trio_t volt;
  curr_trio_t curr;
  temp_deg_t temp_deg;
  logic irq_n;
  logic [23:0] d;
  int error_cnt;
  int checked;
  // A short filter shift keeps the rms units settling quickly.
  line_period_sag_peak_monitor #(.DELAY_AW(6), .RMS_SHIFT(2)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .volt_sample(volt), .curr_sample(curr),
    .temp_sense_deg(temp_deg), .irq_n(irq_n));
  host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Free-running clock of 20 ns.
  always #10 core_clk = ~core_clk;
  // Compares one value and counts the outcome.
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Reads one register and compares it.
  task automatic rc(input logic [5:0] a, input logic [23:0] e);
    u_host.rd(a, d);
    check(d, e);
  endtask : rc
  // Holds one level on all phases for 120 samples spaced 10 cycles apart.
  task automatic hold(input logic [15:0] v, input logic [23:0] c);
    volt = {3{v}};
    curr = {3{c}};
    repeat (120) begin
      @(negedge core_clk);
      sample_valid = 1'b1;
      @(negedge core_clk);
      sample_valid = 1'b0;
      repeat (8) @(negedge core_clk);
    end
  endtask : hold
  // Reset values, an unmapped address and the read-only temperature.
  task automatic t_regs();
    rc(`ADDR_MODE, 24'h000070);
    rc(6'h3e, 24'h000000);
    rc(`ADDR_TEMP, 24'h000002);
    temp_deg = 10'sd125;
    repeat (8) @(negedge core_clk);
    rc(`ADDR_TEMP, 24'h0000ff);
    u_host.wr(`ADDR_TEMP, 16'h0055);
    rc(`ADDR_TEMP, 24'h0000ff);
    // Only the low five bits of a trim are kept; -4 reads back as 1ch.
    u_host.wr(`ADDR_TRIM_A, 16'hfffc);
    rc(`ADDR_TRIM_A, 24'h00001c);
  endtask : t_regs
  // Equal magnitudes are no peak; a negative sample above both thresholds is.
  task automatic t_peak();
    u_host.wr(`ADDR_MODE, 16'h0070);
    u_host.wr(`ADDR_TRIM_A, 16'h0000);
    u_host.wr(`ADDR_VOLTAGE_PEAK_THRESHOLD, 16'h0010);
    u_host.wr(`ADDR_CURRENT_PEAK_THRESHOLD, 16'h0010);
    u_host.wr(`ADDR_IRQ_EN, 16'h0c00);
    hold(16'h1000, 24'h100000);
    rc(`ADDR_STATUS, 24'h000000);
    check({23'h0, irq_n}, 24'h000001);
    hold(16'he000, 24'he00000);
    check({23'h0, irq_n}, 24'h000000);
    rc(`ADDR_STATUS_READ_CLEAR, 24'h000c00);
    rc(`ADDR_STATUS, 24'h000000);
    check({23'h0, irq_n}, 24'h000001);
    // Peak phase code three switches both peak checks off.
    u_host.wr(`ADDR_MODE, 16'h007c);
    hold(16'he000, 24'he00000);
    rc(`ADDR_STATUS, 24'h000000);
    u_host.wr(`ADDR_MODE, 16'h0070);
  endtask : t_peak
  // Two low half cycles after the partial one raise all sag flags, then the period.
  task automatic t_sag();
    u_host.wr(`ADDR_SAG_LVL, 16'h0020);
    u_host.wr(`ADDR_SAG_CYC, 16'h0002);
    u_host.wr(`ADDR_IRQ_EN, 16'h000e);
    hold(16'h0100, 24'h000000);
    rc(`ADDR_STATUS_READ_CLEAR, 24'h000380);
    hold(16'hff00, 24'h000000);
    rc(`ADDR_STATUS, 24'h000000);
    check({23'h0, irq_n}, 24'h000001);
    hold(16'h0100, 24'h000000);
    check({23'h0, irq_n}, 24'h000000);
    rc(`ADDR_STATUS_READ_CLEAR, 24'h00038e);
    // Two full periods of 2400 cycles with no host traffic in between.
    repeat (2) begin
      hold(16'hff00, 24'h000000);
      hold(16'h0100, 24'h000000);
    end
    rc(`ADDR_PERIOD, 24'h000014);
    // Voltage magnitude has been 256 for long; current has been zero.
    rc(`ADDR_RMS_BASE, 24'h000100);
    rc(6'(`ADDR_RMS_BASE + 2), 24'h000100);
    rc(6'(`ADDR_RMS_BASE + 3), 24'h000000);
  endtask : t_sag
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence: reset for two cycles, then the scenarios.
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    sample_valid = 1'b0;
    volt = '0;
    curr = '0;
    temp_deg = 10'sd137;
    error_cnt = 0;
    checked = 0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    t_regs();
    t_peak();
    t_sag();
    report_and_stop();
  end
  // A hang counts as a mismatch.
  initial begin
    #1ms;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
